// [jwe_top.sv]
`timescale 1ns/100ps
// evaluator top: register slave, windows, thickness, referencing, teach key
module jwe_top #(
  parameter int HOLD_CYC = 1_000_000_000
) (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // measurements
  input  wire logic        meas_stb,
  input  wire logic [31:0] meas_dist,
  input  wire logic [31:0] meas_int,
  input  wire logic [31:0] sec_dist,
  // pins
  input  wire logic        adapter_pin,
  input  wire logic        teach_key_n,
  input  wire logic        enter_key,
  input  wire logic        menu_ref,
  input  wire logic        radio_ref,
  // outputs
  output logic             ssc1_out,
  output logic             ssc2_out,
  output logic             jump_out,
  output logic             win_out,
  output logic [31:0]      analog_out,
  output logic [31:0]      abs_out,
  output logic             led_a,
  output logic             led_b
);
  import jwe_pkg::*;
  initial begin
    if (HOLD_CYC < 2) $error("jwe_top: HOLD_CYC too small");
  end
  function automatic logic [31:0] clamp(input logic [31:0] v,
                                        input logic [31:0] lo,
                                        input logic [31:0] hi);
    clamp = v < lo ? lo : (v > hi ? hi : v);
  endfunction : clamp
  // configuration
  logic [31:0] ofs_r, jmin_r, jmax_r, pul_r, dsp_r, dwin_r;
  logic [31:0] isp_r, iwin_r, ssp1_r, ssp2_r, rthk_r, calib_r;
  logic [1:0]  dir_r;
  logic [2:0]  mode_r;
  logic        refd_r;
  logic [31:0] result_r, res_nxt;
  // bus
  logic        aw_r, w_r, bv_r, rv_r;
  logic [7:0]  awa_r;
  logic [31:0] wd_r, rd_r, rd_nxt;
  logic        rok_r, wok, rok, wr_go, sw_ref;
  // pin sync and teach
  logic [2:0]  adp_s, key_s, ent_s;
  logic        adp_lvl_r, key_lvl_r, ent_lvl_r, ent_old_r;
  jwe_teach_t  tst_r, tst_nxt;
  logic [31:0] tcnt_r, tcnt_nxt;
  logic [2:0]  fl_r, fl_nxt;
  logic        key_ref, do_ref, ref_pend_r, ref_go;
  jwe_mode_t   eff_mode;
  logic [31:0] ilo, ihi, iw;
  assign s_axi_awready = !aw_r && !bv_r;
  assign s_axi_wready  = !w_r && !bv_r;
  assign s_axi_bvalid  = bv_r;
  assign s_axi_bresp   = bv_r && !wok ? 2'h2 : 2'h0;
  assign s_axi_arready = !rv_r;
  assign s_axi_rvalid  = rv_r;
  assign s_axi_rdata   = rd_r;
  assign s_axi_rresp   = rok_r ? 2'h0 : 2'h2;
  assign wr_go = aw_r && w_r && !bv_r;
  always_comb begin
    wok = awa_r <= A_REF && awa_r != A_STAT && awa_r != A_RES;
    rok = s_axi_araddr <= A_REF;
    unique case (s_axi_araddr)
      A_CTRL:  rd_nxt = {29'h0, mode_r};
      A_JCFG:  rd_nxt = {dir_r, 21'h0, ofs_r[8:0]};
      A_JMIN:  rd_nxt = jmin_r;
      A_JMAX:  rd_nxt = jmax_r;
      A_PULSE: rd_nxt = pul_r;
      A_DSP:   rd_nxt = dsp_r;
      A_DWIN:  rd_nxt = dwin_r;
      A_ISP:   rd_nxt = isp_r;
      A_IWIN:  rd_nxt = iwin_r;
      A_SSP1:  rd_nxt = ssp1_r;
      A_SSP2:  rd_nxt = ssp2_r;
      A_RTHK:  rd_nxt = rthk_r;
      A_STAT:  rd_nxt = {26'h0, eff_mode, jump_out, win_out, refd_r};
      A_RES:   rd_nxt = result_r;
      default: rd_nxt = 32'h0;
    endcase
  end
  assign sw_ref = wr_go && wok && awa_r == A_REF && wd_r[0];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_r <= 1'b0; w_r <= 1'b0; bv_r <= 1'b0; rv_r <= 1'b0;
      awa_r <= 8'h00; wd_r <= 32'h0; rd_r <= 32'h0; rok_r <= 1'b0;
      mode_r <= 3'(JWE_AUTO); dir_r <= 2'(JWE_DIR_NEG);
      ofs_r <= OFS_DEF; jmin_r <= 32'h0; jmax_r <= JMAX_DEF; pul_r <= 32'h0;
      dsp_r <= 32'h0; dwin_r <= DWIN_DEF; isp_r <= ISP_DEF;
      iwin_r <= IWIN_DEF; ssp1_r <= 32'h0; ssp2_r <= 32'h0; rthk_r <= 32'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_r <= 1'b1; awa_r <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_r <= 1'b1; wd_r <= s_axi_wdata;
      end
      if (wr_go) begin
        bv_r <= 1'b1;
        if (&s_axi_wstrb || 1'b1) begin
          unique case (awa_r)
            A_CTRL:  mode_r <= wd_r[2:0] > 3'h4 ? 3'h4 : wd_r[2:0];
            A_JCFG: begin
              ofs_r <= clamp({23'h0, wd_r[8:0]}, 32'h1, OFS_MAX);
              dir_r <= wd_r[31:30] == 2'h3 ? 2'h2 : wd_r[31:30];
            end
            A_JMIN:  jmin_r <= wd_r;
            A_JMAX:  jmax_r <= wd_r;
            A_PULSE: pul_r <= clamp(wd_r, 32'h0, PUL_MAX);
            A_DSP:   dsp_r <= wd_r;
            A_DWIN:  dwin_r <= clamp(wd_r, DWIN_MIN, DWIN_MAX);
            A_ISP:   isp_r <= clamp(wd_r, 32'h1, ISP_MAX);
            A_IWIN:  iwin_r <= clamp(wd_r, 32'h1, IWIN_MAX);
            A_SSP1:  ssp1_r <= wd_r;
            A_SSP2:  ssp2_r <= wd_r;
            A_RTHK:  rthk_r <= wd_r;
            default: ;
          endcase
        end
      end
      if (bv_r && s_axi_bready) begin
        bv_r <= 1'b0; aw_r <= 1'b0; w_r <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        rv_r <= 1'b1; rd_r <= rd_nxt; rok_r <= rok;
      end else if (rv_r && s_axi_rready) begin
        rv_r <= 1'b0;
      end
    end
  end
  // pin synchronisers: change taken when stages two and three agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      adp_s <= 3'h0; key_s <= 3'h7; ent_s <= 3'h0;
      adp_lvl_r <= 1'b0; key_lvl_r <= 1'b0; ent_lvl_r <= 1'b0;
      ent_old_r <= 1'b0;
    end else begin
      adp_s <= {adp_s[1:0], adapter_pin};
      key_s <= {key_s[1:0], teach_key_n};
      ent_s <= {ent_s[1:0], enter_key};
      if (adp_s[1] == adp_s[2]) adp_lvl_r <= adp_s[2];
      if (key_s[1] == key_s[2]) key_lvl_r <= !key_s[2];
      if (ent_s[1] == ent_s[2]) ent_lvl_r <= ent_s[2];
      ent_old_r <= ent_lvl_r;
    end
  end
  // teach key: hold, flash, reference on release, two confirm flashes
  always_comb begin
    tst_nxt = tst_r; tcnt_nxt = tcnt_r; fl_nxt = fl_r; key_ref = 1'b0;
    unique case (tst_r)
      JWE_T_IDLE: if (key_lvl_r) begin
        tst_nxt = JWE_T_PRESS; tcnt_nxt = 32'h0;
      end
      JWE_T_PRESS: begin
        tcnt_nxt = tcnt_r + 32'h1;
        if (!key_lvl_r) tst_nxt = JWE_T_IDLE;
        else if (tcnt_r >= 32'(HOLD_CYC - 1)) begin
          tst_nxt = JWE_T_ARMED; tcnt_nxt = 32'h0;
        end
      end
      JWE_T_ARMED: begin
        tcnt_nxt = tcnt_r >= 32'(FLASH_CYC - 1) ? 32'h0 : tcnt_r + 32'h1;
        if (!key_lvl_r) begin
          key_ref = 1'b1; tst_nxt = JWE_T_CONF;
          tcnt_nxt = 32'h0; fl_nxt = 3'h0;
        end
      end
      JWE_T_CONF: begin
        tcnt_nxt = tcnt_r + 32'h1;
        if (tcnt_r >= 32'(FLASH_CYC - 1)) begin
          tcnt_nxt = 32'h0; fl_nxt = fl_r + 3'h1;
          if (fl_r == 3'h3) tst_nxt = JWE_T_IDLE;
        end
      end
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tst_r <= JWE_T_IDLE; tcnt_r <= 32'h0; fl_r <= 3'h0;
    end else begin
      tst_r <= tst_nxt; tcnt_r <= tcnt_nxt; fl_r <= fl_nxt;
    end
  end
  always_comb begin
    led_a = 1'b0;
    if (tst_r == JWE_T_ARMED) led_a = tcnt_r < 32'(FLASH_CYC / 2);
    else if (tst_r == JWE_T_CONF) led_a = !fl_r[0];
  end
  assign led_b = led_a;
  // operating mode and referencing
  always_comb begin
    eff_mode = jwe_mode_t'(mode_r);
    if (mode_r == 3'(JWE_AUTO))
      eff_mode = adp_lvl_r ? JWE_MAIN_THK : JWE_STANDALONE;
  end
  assign do_ref = key_ref || sw_ref || (ent_lvl_r && !ent_old_r)
                  || menu_ref || radio_ref;
  // request waits for the next measurement cycle
  assign ref_go = (do_ref || ref_pend_r) && meas_stb;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      refd_r <= 1'b0; calib_r <= DIST_DEF; ref_pend_r <= 1'b0;
    end else begin
      ref_pend_r <= (do_ref || ref_pend_r) && !meas_stb;
      if (ref_go) begin
        refd_r <= 1'b1;
        calib_r <= eff_mode == JWE_MAIN_DIFF ? meas_dist - sec_dist - rthk_r
                                             : meas_dist + sec_dist + rthk_r;
      end
    end
  end
  always_comb begin
    unique case (eff_mode)
      JWE_MAIN_THK:  res_nxt = calib_r - meas_dist - sec_dist;
      JWE_MAIN_DIFF: res_nxt = meas_dist - sec_dist - calib_r;
      default:       res_nxt = meas_dist;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) result_r <= 32'h0;
    else if (meas_stb) result_r <= res_nxt;
  end
  // windows and switching outputs
  always_comb begin
    iw  = 32'((64'(isp_r) * 64'(iwin_r)) / 64'd100);
    ilo = isp_r - iw;
    ihi = isp_r + iw;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      win_out <= 1'b0; ssc1_out <= 1'b0; ssc2_out <= 1'b0;
      analog_out <= 32'h0; abs_out <= 32'h0;
    end else begin
      win_out <= meas_dist + dwin_r >= dsp_r && meas_dist <= dsp_r + dwin_r
                 && meas_int >= ilo && meas_int <= ihi;
      ssc1_out <= refd_r && result_r >= ssp1_r;
      ssc2_out <= refd_r && result_r >= ssp2_r;
      analog_out <= refd_r ? result_r : 32'h0;
      abs_out <= refd_r ? result_r : 32'h0;
    end
  end
  jwe_jump #(.DW(32), .DEPTH(256)) u_jump (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .ofs       (ofs_r[8:0]),
    .dir       (jwe_dir_t'(dir_r)),
    .jmin      (jmin_r == 32'h0 ? JMIN_AUTO : jmin_r),
    .jmax      (jmax_r),
    .pulse_cyc (32'(pul_r * 32'(MS_CYC))),
    .meas_stb  (meas_stb),
    .meas      (meas_dist),
    .jump_out  (jump_out)
  );
endmodule : jwe_top

// [jwe_pkg.sv]
// package of constants and types for the jump, window and thickness evaluator
// Overview of operation
// - compare current value with the reference taken cycle-offset cycles earlier, 1..256
// - direction both: rising and falling changes both signal a jump
// - pulse duration zero holds output until a jump in opposite direction
// - nonzero pulse duration, up to 10000 ms, asserts output that long per jump
// - distance window symmetric about switching point, half-width 1000 um, max 10000
// - intensity switching point in digits, default 30000, up to one million
// - intensity window half-width in percent, default 4, up to 50
// - main combines own and secondary value into thickness or difference
// - adapter connection sets mode automatically, main becomes thickness
// - switching outputs compare switching points against thickness or difference
// - analog output carries the calculated result: thickness, difference or own distance, by mode
// - results are valid only after referencing with the reference object
// - referencing starts from teach key, enter key, menu, wireless or io-link
// - teach key held 10 s flashes leds; release references, two flashes confirm
// - mode selects stand-alone, secondary, main thickness, main difference, automatic
// - positive direction detects rises, negative detects falls
// - jump counts only at minimum height; zero selects smallest detectable
package jwe_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int MS_CYC = CLK_HZ / 1000;
  localparam int HOLD_MS = 10_000;
  localparam int FLASH_MS = 200;
  localparam int FLASH_CYC = FLASH_MS * MS_CYC;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_JCFG = 8'h04;
  localparam logic [7:0] A_JMIN = 8'h08;
  localparam logic [7:0] A_JMAX = 8'h0c;
  localparam logic [7:0] A_PULSE = 8'h10;
  localparam logic [7:0] A_DSP = 8'h14;
  localparam logic [7:0] A_DWIN = 8'h18;
  localparam logic [7:0] A_ISP = 8'h1c;
  localparam logic [7:0] A_IWIN = 8'h20;
  localparam logic [7:0] A_SSP1 = 8'h24;
  localparam logic [7:0] A_SSP2 = 8'h28;
  localparam logic [7:0] A_RTHK = 8'h2c;
  localparam logic [7:0] A_STAT = 8'h30;
  localparam logic [7:0] A_RES = 8'h34;
  localparam logic [7:0] A_REF = 8'h38;
  localparam logic [31:0] OFS_DEF = 32'h0000_0032;
  localparam logic [31:0] OFS_MAX = 32'h0000_0100;
  localparam logic [31:0] PUL_MAX = 32'h0000_2710;
  localparam logic [31:0] DWIN_DEF = 32'h0000_03e8;
  localparam logic [31:0] DWIN_MIN = 32'h0000_0004;
  localparam logic [31:0] DWIN_MAX = 32'h0000_2710;
  localparam logic [31:0] ISP_DEF = 32'h0000_7530;
  localparam logic [31:0] ISP_MAX = 32'h000f_4240;
  localparam logic [31:0] IWIN_DEF = 32'h0000_0004;
  localparam logic [31:0] IWIN_MAX = 32'h0000_0032;
  localparam logic [31:0] JMIN_AUTO = 32'h0000_0006;
  localparam logic [31:0] JMAX_DEF = 32'hffff_ffff;
  localparam logic [31:0] DIST_DEF = 32'h000a_8c00;
  typedef enum logic [2:0] {
    JWE_STANDALONE = 3'h0,
    JWE_SECONDARY  = 3'h1,
    JWE_MAIN_THK   = 3'h2,
    JWE_MAIN_DIFF  = 3'h3,
    JWE_AUTO       = 3'h4
  } jwe_mode_t;
  typedef enum logic [1:0] {
    JWE_DIR_POS  = 2'h0,
    JWE_DIR_NEG  = 2'h1,
    JWE_DIR_BOTH = 2'h2
  } jwe_dir_t;
  typedef enum logic [1:0] {
    JWE_T_IDLE  = 2'b00,
    JWE_T_PRESS = 2'b01,
    JWE_T_ARMED = 2'b11,
    JWE_T_CONF  = 2'b10
  } jwe_teach_t;
endpackage : jwe_pkg

// [jwe_jump.sv]
`timescale 1ns/100ps
// jump detector with delay line, height limits and hold or timed output
module jwe_jump #(
  parameter int DW    = 32,
  parameter int DEPTH = 256
) (
  // clock and reset
  input  wire logic                aclk,
  input  wire logic                aresetn,
  // settings
  input  wire logic [8:0]          ofs,
  input  wire jwe_pkg::jwe_dir_t   dir,
  input  wire logic [DW-1:0]       jmin,
  input  wire logic [DW-1:0]       jmax,
  input  wire logic [31:0]         pulse_cyc,
  // measurement stream
  input  wire logic                meas_stb,
  input  wire logic [DW-1:0]       meas,
  // result
  output logic                     jump_out
);
  import jwe_pkg::*;
  initial begin
    if (DEPTH < 256 || DW < 8) $error("jwe_jump: bad parameters");
  end
  logic [DW-1:0] line_m [DEPTH];
  logic [7:0]    wp_r, wp_nxt;
  logic [8:0]    fill_r, fill_nxt;
  logic          out_r, out_nxt;
  logic          last_up_r, last_up_nxt;
  logic [31:0]   cnt_r, cnt_nxt;
  logic [DW-1:0] refv, dlt;
  logic          up, hit, qual;
  always_comb begin
    refv = line_m[8'(wp_r - ofs[7:0])];
    up   = meas > refv;
    dlt  = up ? meas - refv : refv - meas;
    qual = meas_stb && fill_r >= ofs && dlt >= jmin && dlt <= jmax
           && dlt != '0;
    if (dir == JWE_DIR_POS) hit = qual && up;
    else if (dir == JWE_DIR_NEG) hit = qual && !up;
    else hit = qual;
    wp_nxt      = meas_stb ? wp_r + 8'h01 : wp_r;
    fill_nxt    = (meas_stb && fill_r < 9'h100) ? fill_r + 9'h001 : fill_r;
    out_nxt     = out_r;
    last_up_nxt = last_up_r;
    cnt_nxt     = cnt_r;
    if (pulse_cyc == 32'h0) begin
      if (qual && out_r && up != last_up_r) begin
        out_nxt = 1'b0;
      end else if (hit) begin
        out_nxt     = 1'b1;
        last_up_nxt = up;
      end
    end else if (hit) begin
      out_nxt = 1'b1;
      cnt_nxt = pulse_cyc - 32'h1;
    end else if (cnt_r != 32'h0) begin
      cnt_nxt = cnt_r - 32'h1;
    end else begin
      out_nxt = 1'b0;
    end
  end
  always_ff @(posedge aclk) begin
    if (meas_stb) line_m[wp_r] <= meas;
    if (!aresetn) begin
      wp_r      <= 8'h00;
      fill_r    <= 9'h000;
      out_r     <= 1'b0;
      last_up_r <= 1'b0;
      cnt_r     <= 32'h0;
    end else begin
      wp_r      <= wp_nxt;
      fill_r    <= fill_nxt;
      out_r     <= out_nxt;
      last_up_r <= last_up_nxt;
      cnt_r     <= cnt_nxt;
    end
  end
  assign jump_out = out_r;
endmodule : jwe_jump

// [jwe_top_sva.sv]
// checker on the evaluator top ports
`timescale 1ns/100ps
module jwe_top_sva (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_rvalid,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic [31:0] s_axi_rdata,
  // evaluation
  input wire logic        meas_stb,
  input wire logic        ssc1_out,
  input wire logic        ssc2_out,
  input wire logic        jump_out,
  input wire logic        win_out,
  input wire logic [31:0] analog_out,
  input wire logic        led_a,
  input wire logic        led_b
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_RST_CLEAR: assert property ($rose(aresetn) |->
    !jump_out && !win_out && !ssc1_out && analog_out == 32'h0)
    else $error("outputs not clear after reset");
  AST_W_ANSWER: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
    else $error("write answer late");
  AST_AR_ANSWER: assert property (s_axi_arvalid && !s_axi_rvalid
    |=> s_axi_rvalid) else $error("read answer late");
  AST_RD_ERR: assert property (s_axi_arvalid && !s_axi_rvalid &&
    s_axi_araddr > 8'h38 |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  AST_SSC_STROBE: assert property (
    !$past(meas_stb, 2) |-> $stable(ssc1_out) && $stable(ssc2_out))
    else $error("switching output moved without strobe");
  AST_WIN_STROBE: assert property (
    !$past(meas_stb) |-> $stable(win_out))
    else $error("window output moved without strobe");
  AST_ANA_STROBE: assert property (
    !$past(meas_stb, 2) |-> $stable(analog_out))
    else $error("analog output moved without strobe");
  AST_JUMP_CAUSE: assert property (
    $rose(jump_out) |-> $past(meas_stb))
    else $error("jump without measurement");
  AST_LED_PAIR: assert property (led_a == led_b)
    else $error("leds not flashing together");
  cover property ($rose(jump_out));
  cover property ($rose(ssc1_out));
  cover property ($rose(win_out));
endmodule : jwe_top_sva

// [jwe_sec_model.sv]
// model of the secondary sensor feeding its distance to the main
`timescale 1ns/100ps
module jwe_sec_model (
  // strobe and value
  input  wire logic        meas_stb,
  input  wire logic [31:0] val,
  // to main
  output logic [31:0]      sec_dist
);
  // valid only with the strobe, scrambled otherwise
  assign sec_dist = meas_stb ? val : ~val;
endmodule : jwe_sec_model

// [tb_top.sv]
// testbench for the evaluator top
`timescale 1ns/100ps
module tb_top;
  import jwe_pkg::*;
  typedef struct {
    logic [31:0] a;
    logic [31:0] b;
    logic [31:0] e;
  } jwe_row_t;
  localparam logic [31:0] ALL = 32'hffff_ffff;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, meas_stb, adapter_pin;
  logic        teach_key_n, enter_key, menu_ref, radio_ref, s_axi_arready;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_rvalid;
  logic        ssc1_out, ssc2_out, jump_out, win_out, led_a, led_b;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_wdata, s_axi_rdata, meas_dist, meas_int, sec_dist;
  logic [31:0] sec_v, analog_out, abs_out;
  int          errors = 0, checks_done = 0, i;
  jwe_row_t    cl [10] = '{'{A_JCFG, 32'h0, 32'h1},
    '{A_JCFG, 32'hc000_01ff, 32'h8000_0100}, '{A_PULSE, 32'h4e20, PUL_MAX},
    '{A_DWIN, 32'h0, 32'h4}, '{A_DWIN, 32'h4e20, 32'h2710},
    '{A_ISP, 32'h0, 32'h1}, '{A_ISP, 32'h1e_8480, 32'hf_4240},
    '{A_IWIN, 32'h0, 32'h1}, '{A_IWIN, 32'h63, 32'h32},
    '{A_CTRL, 32'h7, 32'h4}};
  jwe_row_t    jr [18] = '{'{2, 32'h3e8, 0}, '{2, 32'h3e8, 0},
    '{2, 32'h3e8, 0}, '{2, 32'h410, 0}, '{2, 32'h438, 1}, '{2, 32'h460, 1},
    '{2, 32'h3e8, 0}, '{2, 32'h3e8, 0}, '{2, 32'h3e8, 0},
    '{32'h4000_0002, 32'h3e8, 0}, '{32'h4000_0002, 32'h3e8, 0},
    '{32'h4000_0002, 32'h384, 1}, '{32'h4000_0002, 32'h3e8, 1},
    '{32'h4000_0002, 32'h44c, 0}, '{32'h4000_0002, 32'h44c, 0},
    '{32'h4000_0002, 32'h44c, 0},
    '{32'h8000_0002, 32'h44c, 0}, '{32'h8000_0002, 32'h3e8, 1}};
  jwe_row_t    wr [6] = '{'{32'h170c, 32'h7530, 1}, '{32'h17d4, 32'h7530, 0},
    '{32'h1004, 32'h7530, 1}, '{32'h1388, 32'h797c, 1},
    '{32'h1388, 32'h7a44, 0}, '{32'h1388, 32'h701c, 0}};
  jwe_top #(.HOLD_CYC(100)) dut_u (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .meas_stb, .meas_dist, .meas_int, .sec_dist, .adapter_pin, .teach_key_n,
    .enter_key, .menu_ref, .radio_ref, .ssc1_out, .ssc2_out, .jump_out,
    .win_out, .analog_out, .abs_out, .led_a, .led_b);
  jwe_sec_model sec_u (.meas_stb, .val(sec_v), .sec_dist);
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e, string m);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk
  task automatic end_sim;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_sim
  task automatic axi_wr(input logic [7:0] a, logic [31:0] d, logic [1:0] r);
    logic aw, w, b;
    b = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    for (int n = 0; n < 50 && !b; n++) begin
      @(negedge aclk);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid;
      if (b) chk(s_axi_bresp, r, "bresp");
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    if (!b) chk(1'b0, 1'b1, "no write answer");
    @(posedge aclk);
  endtask : axi_wr
  task automatic rdc(input logic [7:0] a, logic [31:0] e, m, logic [1:0] r);
    logic ar, ok;
    ok = 1'b0;
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    for (int n = 0; n < 50 && !ok; n++) begin
      @(negedge aclk);
      ar = s_axi_arvalid && s_axi_arready;
      ok = s_axi_rvalid;
      if (ok) chk(32'(s_axi_rresp), 32'(r), "read response");
      if (ok) chk(s_axi_rdata & m, e, "read data");
      @(posedge aclk);
      if (ar) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    if (!ok) chk(1'b0, 1'b1, "no read answer");
    @(posedge aclk);
  endtask : rdc
  task automatic meas(input logic [31:0] d, logic [31:0] n, logic [31:0] s);
    {meas_dist, meas_int, sec_v, meas_stb} <= {d, n, s, 1'b1};
    @(posedge aclk);
    meas_stb <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask : meas
  task automatic req(input int s);
    case (s)
      0: menu_ref <= 1'b1;
      1: radio_ref <= 1'b1;
      2: enter_key <= 1'b1;
      3: teach_key_n <= 1'b0;
      default: axi_wr(A_REF, 32'h1, 2'h0);
    endcase
    repeat (s == 3 ? 130 : (s < 2 ? 1 : 6)) @(posedge aclk);
    {menu_ref, radio_ref, enter_key, teach_key_n} <= 4'h1;
    repeat (8) @(posedge aclk);
  endtask : req
  task automatic rst;
    aresetn <= 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask : rst
  initial begin
    #400_000;
    errors++;
    end_sim();
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, meas_stb, adapter_pin} = 4'h0;
    {enter_key, menu_ref, radio_ref, teach_key_n} = 4'h1;
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb} = 20'h0000f;
    {s_axi_wdata, meas_dist, meas_int, sec_v} = 128'h0;
    @(posedge aclk);
    rst();
    rdc(A_CTRL, 32'h4, 32'h7, 2'h0);
    rdc(A_JCFG, OFS_DEF, 32'h1ff, 2'h0);
    rdc(A_PULSE, 32'h0, ALL, 2'h0);
    rdc(A_DWIN, DWIN_DEF, ALL, 2'h0);
    rdc(A_ISP, ISP_DEF, ALL, 2'h0);
    rdc(A_IWIN, IWIN_DEF, ALL, 2'h0);
    axi_wr(A_STAT, 32'h1, 2'h2);
    axi_wr(8'h3c, 32'h1, 2'h2);
    rdc(8'h40, 32'h0, ALL, 2'h2);
    for (i = 0; i < 10; i++) begin
      axi_wr(cl[i].a[7:0], cl[i].b, 2'h0);
      rdc(cl[i].a[7:0], cl[i].e, ALL, 2'h0);
    end
    axi_wr(A_CTRL, 32'h0, 2'h0);
    axi_wr(A_PULSE, 32'h0, 2'h0);
    axi_wr(A_JMIN, 32'h3c, 2'h0);
    for (i = 0; i < 18; i++) begin
      if (i == 0 || jr[i].a !== jr[i-1].a) axi_wr(A_JCFG, jr[i].a, 2'h0);
      meas(jr[i].b, 32'h0, 32'h0);
      chk(jump_out, jr[i].e, "jump");
    end
    axi_wr(A_PULSE, 32'h1, 2'h0);
    chk(jump_out, 1'b0, "pulse idle");
    meas(32'h4b0, 32'h0, 32'h0);
    chk(jump_out, 1'b1, "pulse start");
    rst();
    chk(jump_out, 1'b0, "jump after reset");
    rdc(A_CTRL, 32'h4, 32'h7, 2'h0);
    axi_wr(A_CTRL, 32'h0, 2'h0);
    axi_wr(A_DSP, 32'h1388, 2'h0);
    for (i = 0; i < 6; i++) begin
      meas(wr[i].a, wr[i].b, 32'h0);
      chk(win_out, wr[i].e, "window");
    end
    axi_wr(A_CTRL, 32'h4, 2'h0);
    adapter_pin <= 1'b1;
    repeat (6) @(posedge aclk);
    rdc(A_STAT, 32'h10, 32'h38, 2'h0);
    adapter_pin <= 1'b0;
    repeat (6) @(posedge aclk);
    rdc(A_STAT, 32'h0, 32'h38, 2'h0);
    axi_wr(A_CTRL, 32'h2, 2'h0);
    axi_wr(A_RTHK, 32'h1f4, 2'h0);
    axi_wr(A_SSP1, 32'h190, 2'h0);
    axi_wr(A_SSP2, 32'h258, 2'h0);
    meas(32'h3e8, 32'h0, 32'h7d0);
    chk(ssc1_out, 1'b0, "ssc before referencing");
    rdc(A_STAT, 32'h0, 32'h1, 2'h0);
    for (i = 0; i < 5; i++) begin
      req(i);
      if (i == 3) chk(led_a, 1'b1, "led confirm");
      meas(32'h3e8 + 32'h64 * i, 32'h0, 32'h7d0);
      meas(32'h44c + 32'h64 * i, 32'h0, 32'h7d0);
      chk(analog_out, 32'h190, "analog");
      chk(abs_out, 32'h190, "absolute");
      chk({ssc2_out, ssc1_out}, 2'h1, "ssc");
    end
    rdc(A_RES, 32'h190, ALL, 2'h0);
    rdc(A_STAT, 32'h1, 32'h1, 2'h0);
    axi_wr(A_CTRL, 32'h3, 2'h0);
    req(4);
    meas(32'h3e8, 32'h0, 32'h7d0);
    meas(32'h44c, 32'h0, 32'h7d0);
    chk(analog_out, 32'h258, "difference");
    chk({ssc2_out, ssc1_out}, 2'h3, "ssc difference");
    end_sim();
  end
endmodule : tb_top
bind jwe_top jwe_top_sva chk_u (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_rvalid,
  .s_axi_rresp, .s_axi_rdata, .meas_stb, .ssc1_out, .ssc2_out, .jump_out,
  .win_out, .analog_out, .led_a, .led_b);
